// ==== inc/pfr_pkg.sv ====
package pfr_pkg;
  // Shared register file geometry
  localparam int NUM_REGS = 8;
  localparam int IDX_W = 3;
  localparam int PK_W = 64;
  localparam int FP_W = 80;
  localparam int XR_W = 128;
  // Memory reference sizes in bytes; alignment and address widths in bits
  localparam int PK_BYTES = 8;
  localparam int XR_BYTES = 16;
  localparam int XR_ALIGN_W = 4;
  localparam int ADDR_W = 32;
  localparam int LINE_BYTES = 64;
  // Tag word values
  localparam logic [NUM_REGS-1:0] TAG_ALL = 8'hFF;
  localparam logic [NUM_REGS-1:0] TAG_NONE = 8'h00;
  // Reset values
  localparam logic [IDX_W-1:0] TOP_RST = 3'h0;
  localparam logic [FP_W-1:0] FP_RST = 80'h0;
  localparam logic [XR_W-1:0] XR_RST = 128'h0;
endpackage : pfr_pkg

// ==== hw/pfr_align_chk.sv ====
`timescale 1ns/1ps
module pfr_align_chk #(
  parameter int ADDR_W = pfr_pkg::ADDR_W,
  parameter int LINE_BYTES = pfr_pkg::LINE_BYTES
) (
  // Reference
  input wire logic [ADDR_W-1:0] addr,
  input wire logic wide,
  input wire logic unaligned_ok,
  // Verdict
  output logic fault,
  output logic split
);
  localparam int LW = $clog2(LINE_BYTES);
  localparam logic [LW:0] LINE_SZ = (LW+1)'(LINE_BYTES);
  localparam logic [LW:0] PK_SZ = (LW+1)'(pfr_pkg::PK_BYTES);

  logic [LW:0] end_off;

  if (LINE_BYTES < pfr_pkg::XR_BYTES || (LINE_BYTES & (LINE_BYTES - 1)) != 0 ||
      ADDR_W < LW) begin : g_chk
    $error("pfr_align_chk: LINE_BYTES must be a power of two of at least 16 within ADDR_W");
  end

  always_comb begin
    end_off = {1'b0, addr[LW-1:0]} + PK_SZ;
    // Wide references fault off a 16-byte boundary unless the unaligned move is used
    fault = wide && !unaligned_ok && (addr[pfr_pkg::XR_ALIGN_W-1:0] != '0); // [RL6]
    // Narrow references never fault; crossing a line only costs a second access
    split = !wide && (end_off > LINE_SZ); // [RL7]
  end
endmodule : pfr_align_chk

// ==== hw/pfr_regfile.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// RL1: Each 64-bit packed register is the low 64 bits of one floating-point stack register.
// RL2: Any packed register reference sets all eight tag valid bits.
// RL3: The empty-state instruction clears all eight tag valid bits.
// RL4: The 128-bit register set is separate and never touches stack registers or tags.
// RL5: A push onto a slot still marked valid raises a stack overflow exception.
// RL6: A 128-bit memory reference off a 16-byte boundary faults unless the unaligned move.
// RL7: A misaligned 64-bit reference completes without fault and may split over 2 lines.
// RL8: Issue logic is expected to run the empty-state instruction before stack code follows.
// RL9: The tag word holds eight bits and set-all or clear-all updates them in one cycle.
module pfr_regfile #(
  parameter int ADDR_W = pfr_pkg::ADDR_W,
  parameter int LINE_BYTES = pfr_pkg::LINE_BYTES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Packed 64-bit view, absolute index
  input wire logic pk_wr_en,
  input wire logic [pfr_pkg::IDX_W-1:0] pk_wr_idx,
  input wire logic [pfr_pkg::PK_W-1:0] pk_wr_data,
  input wire logic pk_rd_en,
  input wire logic [pfr_pkg::IDX_W-1:0] pk_rd_idx,
  output logic [pfr_pkg::PK_W-1:0] pk_rd_data,
  // Empty-state instruction
  input wire logic empty_state_intrinsic,
  // Floating-point stack view, relative to top
  input wire logic fp_push,
  input wire logic [pfr_pkg::FP_W-1:0] fp_push_data,
  input wire logic fp_pop,
  input wire logic fp_wr_en,
  input wire logic [pfr_pkg::IDX_W-1:0] fp_wr_sti,
  input wire logic [pfr_pkg::FP_W-1:0] fp_wr_data,
  input wire logic fp_rd_en,
  input wire logic [pfr_pkg::IDX_W-1:0] fp_rd_sti,
  output logic [pfr_pkg::FP_W-1:0] fp_rd_data,
  output logic fp_overflow,
  output logic fp_underflow,
  output logic [pfr_pkg::NUM_REGS-1:0] tag_word,
  output logic [pfr_pkg::IDX_W-1:0] fp_top,
  // Separate 128-bit register set
  input wire logic xr_wr_en,
  input wire logic [pfr_pkg::IDX_W-1:0] xr_wr_idx,
  input wire logic [pfr_pkg::XR_W-1:0] xr_wr_data,
  input wire logic xr_rd_en,
  input wire logic [pfr_pkg::IDX_W-1:0] xr_rd_idx,
  output logic [pfr_pkg::XR_W-1:0] xr_rd_data,
  // Memory reference alignment check
  input wire logic mem_req,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic mem_wide,
  input wire logic mem_unaligned_ok,
  output logic mem_ack,
  output logic mem_fault,
  output logic mem_split
);
  localparam int N = pfr_pkg::NUM_REGS;
  localparam int IW = pfr_pkg::IDX_W;

  typedef struct packed {
    logic [N-1:0][pfr_pkg::FP_W-1:0] st;
    logic [N-1:0][pfr_pkg::XR_W-1:0] xr;
    logic [N-1:0] tag;
    logic [IW-1:0] top;
    logic [pfr_pkg::PK_W-1:0] pk_rd;
    logic [pfr_pkg::FP_W-1:0] fp_rd;
    logic [pfr_pkg::XR_W-1:0] xr_rd;
    logic ovf;
    logic unf;
    logic ack;
    logic fault;
    logic split;
  } pfr_state_s;

  pfr_state_s s_q;
  pfr_state_s s_d;
  logic chk_fault;
  logic chk_split;
  logic pk_ref;
  logic [IW-1:0] push_slot;
  logic push_ok;
  logic pop_ok;

  if (N != 8 || IW != $clog2(N) || ADDR_W < pfr_pkg::XR_ALIGN_W) begin : g_chk
    $error("pfr_regfile: unsupported geometry");
  end

  function automatic logic [IW-1:0] phys(input logic [IW-1:0] top, input logic [IW-1:0] sti);
    phys = IW'(top + sti);
  endfunction : phys

  pfr_align_chk #(
    .ADDR_W(ADDR_W),
    .LINE_BYTES(LINE_BYTES)
  ) u_align (
    .addr(mem_addr),
    .wide(mem_wide),
    .unaligned_ok(mem_unaligned_ok),
    .fault(chk_fault),
    .split(chk_split)
  );

  always_comb begin
    s_d = s_q;
    pk_ref = pk_wr_en || pk_rd_en;
    push_slot = IW'(s_q.top - 3'h1);
    push_ok = fp_push && !s_q.tag[push_slot]; // [RL5]
    pop_ok = fp_pop && !fp_push && s_q.tag[s_q.top];
    s_d.ovf = fp_push && s_q.tag[push_slot]; // [RL5]
    s_d.unf = fp_pop && !fp_push && !s_q.tag[s_q.top];
    // Reads return the value held before this cycle's writes
    if (pk_rd_en) begin
      s_d.pk_rd = s_q.st[pk_rd_idx][pfr_pkg::PK_W-1:0]; // [RL1]
    end
    if (fp_rd_en) begin
      s_d.fp_rd = s_q.st[phys(s_q.top, fp_rd_sti)];
    end
    if (xr_rd_en) begin
      s_d.xr_rd = s_q.xr[xr_rd_idx];
    end
    // Both views write the same storage; later writes in this order win
    if (pk_wr_en) begin
      s_d.st[pk_wr_idx][pfr_pkg::PK_W-1:0] = pk_wr_data; // [RL1]
    end
    if (fp_wr_en) begin
      s_d.st[phys(s_q.top, fp_wr_sti)] = fp_wr_data; // [RL1]
      s_d.tag[phys(s_q.top, fp_wr_sti)] = 1'b1;
    end
    if (push_ok) begin
      s_d.st[push_slot] = fp_push_data;
      s_d.tag[push_slot] = 1'b1;
      s_d.top = push_slot;
    end else if (pop_ok) begin
      s_d.tag[s_q.top] = 1'b0;
      s_d.top = IW'(s_q.top + 3'h1);
    end
    // Wide set has its own storage and leaves stack and tags alone
    if (xr_wr_en) begin
      s_d.xr[xr_wr_idx] = xr_wr_data; // [RL4]
    end
    // Clear-all then set-all, so a packed reference wins over empty-state
    for (int i = 0; i < N; i++) begin
      if (empty_state_intrinsic) begin
        s_d.tag[i] = 1'b0; // [RL3] [RL9]
      end
      if (pk_ref) begin
        s_d.tag[i] = 1'b1; // [RL2] [RL9]
      end
    end
    s_d.ack = mem_req;
    s_d.fault = mem_req && chk_fault; // [RL6]
    s_d.split = mem_req && chk_split; // [RL7]
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q.st <= {N{pfr_pkg::FP_RST}};
      s_q.xr <= {N{pfr_pkg::XR_RST}};
      s_q.tag <= pfr_pkg::TAG_NONE;
      s_q.top <= pfr_pkg::TOP_RST;
      s_q.pk_rd <= '0;
      s_q.fp_rd <= pfr_pkg::FP_RST;
      s_q.xr_rd <= pfr_pkg::XR_RST;
      s_q.ovf <= 1'b0;
      s_q.unf <= 1'b0;
      s_q.ack <= 1'b0;
      s_q.fault <= 1'b0;
      s_q.split <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pk_rd_data = s_q.pk_rd;
  assign fp_rd_data = s_q.fp_rd;
  assign xr_rd_data = s_q.xr_rd;
  assign fp_overflow = s_q.ovf;
  assign fp_underflow = s_q.unf;
  assign tag_word = s_q.tag;
  assign fp_top = s_q.top;
  assign mem_ack = s_q.ack;
  assign mem_fault = s_q.fault;
  assign mem_split = s_q.split;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  property p_pk_alias;
    (pk_wr_en && !fp_wr_en && !push_ok)
      |=> s_q.st[$past(pk_wr_idx)][pfr_pkg::PK_W-1:0] == $past(pk_wr_data);
  endproperty
  a_pk_alias: assert property (p_pk_alias) else $error("packed write not seen in stack"); // [RL1]

  property p_pk_read;
    (pk_rd_en && !pk_wr_en && !fp_wr_en && !fp_push ##1 pk_rd_en && pk_rd_idx == $past(pk_rd_idx))
      |=> pk_rd_data == $past(pk_rd_data, 1);
  endproperty
  a_pk_read: assert property (p_pk_read) else $error("packed read unstable"); // [RL1]

  property p_tag_set;
    pk_ref |=> tag_word == pfr_pkg::TAG_ALL;
  endproperty
  a_tag_set: assert property (p_tag_set) else $error("packed reference left tags clear"); // [RL2]

  property p_tag_clr;
    (empty_state_intrinsic && !pk_ref && !fp_push && !fp_wr_en) |=> tag_word == pfr_pkg::TAG_NONE;
  endproperty
  a_tag_clr: assert property (p_tag_clr) else $error("empty-state left tags set"); // [RL3]

  property p_xr_sep;
    (xr_wr_en && !pk_ref && !empty_state_intrinsic && !fp_push && !fp_pop && !fp_wr_en)
      |=> $stable(tag_word) && $stable(s_q.st) && $stable(fp_top);
  endproperty
  a_xr_sep: assert property (p_xr_sep) else $error("wide write disturbed stack"); // [RL4]

  property p_ovf;
    (fp_push && tag_word == pfr_pkg::TAG_ALL) |=> fp_overflow && $stable(fp_top);
  endproperty
  a_ovf: assert property (p_ovf) else $error("push on full tags did not overflow"); // [RL5]

  property p_ovf_cause;
    fp_overflow |-> $past(fp_push) && !$past(push_ok);
  endproperty
  a_ovf_cause: assert property (p_ovf_cause) else $error("spurious overflow"); // [RL5]

  property p_wide_fault;
    (mem_req && mem_wide && !mem_unaligned_ok && mem_addr[3:0] != 4'h0) |=> mem_fault && mem_ack;
  endproperty
  a_wide_fault: assert property (p_wide_fault) else $error("unaligned wide ref did not fault"); // [RL6]

  property p_wide_ok;
    (mem_req && mem_wide && (mem_unaligned_ok || mem_addr[3:0] == 4'h0)) |=> !mem_fault;
  endproperty
  a_wide_ok: assert property (p_wide_ok) else $error("legal wide ref faulted"); // [RL6]

  property p_narrow;
    (mem_req && !mem_wide) |=> mem_ack && !mem_fault;
  endproperty
  a_narrow: assert property (p_narrow) else $error("narrow ref faulted"); // [RL7]

  property p_tag_atomic;
    ($changed(tag_word) && !$past(fp_push) && !$past(fp_pop) && !$past(fp_wr_en))
      |-> tag_word == pfr_pkg::TAG_ALL || tag_word == pfr_pkg::TAG_NONE;
  endproperty
  a_tag_atomic: assert property (p_tag_atomic) else $error("partial tag update"); // [RL9]

  c_pk_then_empty: cover property (pk_ref ##[1:4] empty_state_intrinsic ##2 fp_push);
  c_overflow: cover property (pk_ref ##[1:4] fp_push ##1 fp_overflow);
  c_wide_fault: cover property (mem_req && mem_wide ##1 mem_fault);
  c_split: cover property (mem_req && !mem_wide ##1 mem_split);
endmodule : pfr_regfile

// ==== testbench/pfr_issue_model.sv ====
`timescale 1ns/1ps
module pfr_issue_model (
  // Clock
  input wire logic clk_sys,
  // One-hot issue strobes and shared operands
  output logic [8:0] stb,
  output logic [2:0] idx,
  output logic [127:0] dat,
  output logic [1:0] mode
);
  initial begin
    stb = 9'h000;
    idx = 3'h0;
    dat = 128'h0;
    mode = 2'h0;
  end

  // One request, held over n back-to-back taking edges, dropped after the last
  task automatic issue_n(input int k, input logic [2:0] i, input logic [127:0] d,
                         input logic [1:0] m, input int n);
    @(posedge clk_sys);
    #1;
    stb = 9'h001 << k;
    idx = i;
    dat = d;
    mode = m;
    repeat (n) @(posedge clk_sys);
    #1;
    stb = 9'h000;
  endtask : issue_n

  // One request, held over exactly one taking edge, dropped after it
  task automatic issue(input int k, input logic [2:0] i, input logic [127:0] d,
                       input logic [1:0] m);
    issue_n(k, i, d, m, 1);
  endtask : issue

  // Stack code after packed code always starts with the empty-state step
  task automatic fp_code(input logic [127:0] d);
    issue(2, 3'h0, 128'h0, 2'h0);
    issue(3, 3'h0, d, 2'h0);
  endtask : fp_code
endmodule : pfr_issue_model

// ==== testbench/test_packed_fp_shared_regfile.sv ====
`timescale 1ns/1ps
module test_packed_fp_shared_regfile;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [8:0] stb;
  logic [2:0] idx;
  logic [127:0] dat;
  logic [1:0] mode;
  logic [63:0] pk_rd_data;
  logic [79:0] fp_rd_data;
  logic [127:0] xr_rd_data;
  logic fp_overflow, fp_underflow, mem_ack, mem_fault, mem_split;
  logic [7:0] tag_word;
  logic [2:0] fp_top;
  int error_cnt = 0;
  int cmp_count = 0;

  always #4 clk_sys = ~clk_sys;

  pfr_issue_model pfr_issue_model_inst (.clk_sys(clk_sys), .stb(stb), .idx(idx), .dat(dat),
    .mode(mode));

  pfr_regfile pfr_regfile_inst (.clk_sys(clk_sys), .rst(rst),
    .pk_wr_en(stb[0]), .pk_wr_idx(idx), .pk_wr_data(dat[63:0]), .pk_rd_en(stb[1]),
    .pk_rd_idx(idx), .pk_rd_data(pk_rd_data), .empty_state_intrinsic(stb[2]),
    .fp_push(stb[3]), .fp_push_data(dat[79:0]), .fp_pop(stb[4]), .fp_wr_en(1'b0),
    .fp_wr_sti(3'h0), .fp_wr_data(80'h0), .fp_rd_en(stb[5]), .fp_rd_sti(idx),
    .fp_rd_data(fp_rd_data), .fp_overflow(fp_overflow), .fp_underflow(fp_underflow),
    .tag_word(tag_word), .fp_top(fp_top), .xr_wr_en(stb[6]), .xr_wr_idx(idx),
    .xr_wr_data(dat), .xr_rd_en(stb[7]), .xr_rd_idx(idx), .xr_rd_data(xr_rd_data),
    .mem_req(stb[8]), .mem_addr(dat[31:0]), .mem_wide(mode[1]),
    .mem_unaligned_ok(mode[0]), .mem_ack(mem_ack), .mem_fault(mem_fault),
    .mem_split(mem_split));

  task automatic chk(input string what, input logic [127:0] seen, input logic [127:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  // Push onto an empty stack, then alias a packed write onto the same slot
  task automatic t_alias();
    pfr_issue_model_inst.issue(3, 3'h0, 128'h1234_0000_0000_0000_0000, 2'h0);
    chk("top", fp_top, 3'h7);
    chk("tag", tag_word, 8'h80);
    pfr_issue_model_inst.issue(0, 3'h7, 128'hDEAD_BEEF_0123_4567, 2'h0);
    chk("tag", tag_word, 8'hFF);
    pfr_issue_model_inst.issue(5, 3'h0, 128'h0, 2'h0);
    chk("fp_rd", fp_rd_data, 80'h1234_DEAD_BEEF_0123_4567);
    pfr_issue_model_inst.issue(1, 3'h7, 128'h0, 2'h0);
    chk("pk_rd", pk_rd_data, 64'hDEAD_BEEF_0123_4567);
  endtask : t_alias

  // Tags left full by packed use make the next push overflow
  task automatic t_overflow();
    pfr_issue_model_inst.issue(3, 3'h0, 128'h5, 2'h0);
    chk("ovf", fp_overflow, 1'b1);
    chk("top", fp_top, 3'h7);
    chk("tag", tag_word, 8'hFF);
  endtask : t_overflow

  // Empty-state clears every tag, so stack code runs clean afterwards
  task automatic t_empty();
    pfr_issue_model_inst.fp_code(128'h77);
    chk("ovf", fp_overflow, 1'b0);
    chk("tag", tag_word, 8'h40);
    chk("top", fp_top, 3'h6);
    pfr_issue_model_inst.issue(4, 3'h0, 128'h0, 2'h0);
    pfr_issue_model_inst.issue(4, 3'h0, 128'h0, 2'h0);
    chk("unf", fp_underflow, 1'b1);
  endtask : t_empty

  // The wide set leaves stack and tags alone
  task automatic t_wide();
    pfr_issue_model_inst.issue(6, 3'h3, 128'hC0DE_0000_1111_2222_3333_4444_5555_6666, 2'h0);
    chk("tag", tag_word, 8'h00);
    chk("top", fp_top, 3'h7);
    pfr_issue_model_inst.issue(7, 3'h3, 128'h0, 2'h0);
    chk("xr_rd", xr_rd_data, 128'hC0DE_0000_1111_2222_3333_4444_5555_6666);
    // Back-to-back packed reads see the value pushed through the stack view
    pfr_issue_model_inst.issue_n(1, 3'h6, 128'h0, 2'h0, 2);
    chk("pk_rd", pk_rd_data, 64'h77);
    chk("tag", tag_word, 8'hFF);
  endtask : t_wide

  // Alignment verdicts; mode is {wide, unaligned_ok}, expect is {fault, split}
  task automatic t_align();
    logic [31:0] ad [5] = '{32'h10, 32'h8, 32'h8, 32'h3C, 32'h38};
    logic [1:0] md [5] = '{2'h2, 2'h2, 2'h3, 2'h0, 2'h0};
    logic [1:0] ex [5] = '{2'h0, 2'h2, 2'h0, 2'h1, 2'h0};
    for (int n = 0; n < 5; n++) begin
      pfr_issue_model_inst.issue(8, 3'h0, {96'h0, ad[n]}, md[n]);
      chk("ack", mem_ack, 1'b1);
      chk("fault", mem_fault, ex[n][1]);
      chk("split", mem_split, ex[n][0]);
    end
  endtask : t_align

  initial begin
    repeat (4) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    chk("tag", tag_word, 8'h00);
    chk("top", fp_top, 3'h0);
    t_alias();
    t_overflow();
    t_empty();
    t_wide();
    t_align();
    summarize();
  end

  initial begin
    #20000;
    error_cnt++;
    summarize();
  end
endmodule : test_packed_fp_shared_regfile
